//--- fwl_regs.svh
// register offsets, field positions, reset values and timing counts of the flash row write sequencer
`ifndef FWL_REGS_SVH
`define FWL_REGS_SVH

// =====================================================================
// register offsets (byte addresses on the plain register port)
`define FWL_OFS_DATA_LOW     4'h0
`define FWL_OFS_DATA_HIGH    4'h1
`define FWL_OFS_ADDR_LOW     4'h2
`define FWL_OFS_ADDR_HIGH    4'h3
`define FWL_OFS_CONTROL_ONE  4'h4
`define FWL_OFS_UNLOCK_PORT  4'h5
`define FWL_OFS_STATUS       4'h6

// =====================================================================
// control one field positions
`define FWL_BIT_READ         0
`define FWL_BIT_TRIGGER      1
`define FWL_BIT_WRITE_ENABLE_BIT         2
`define FWL_BIT_ERR          3
`define FWL_BIT_ERASE        4
`define FWL_BIT_LATCH_ONLY_MODE         5
`define FWL_BIT_CONFIG_SPACE_SELECT         6

// =====================================================================
// unlock keys, blank value, latch geometry
`define FWL_KEY_FIRST        8'h55
`define FWL_KEY_SECOND       8'haa
`define FWL_BLANK_WORD       14'h3fff
`define FWL_LATCH_COUNT      32
`define FWL_LATCH_AW         5
`define FWL_ROW_AW           10

// =====================================================================
// timing: forced no-op cycles and self-timed program/erase time
`define FWL_NOP_CYCLES       2
`define FWL_CLK_HZ           50000000
`define FWL_PROG_TIME_US     2000
`define FWL_PROG_CYCLES      ((`FWL_PROG_TIME_US * (`FWL_CLK_HZ / 1000000)))

`endif

//--- fwl_pkg.sv
// types shared by the flash row write sequencer
package fwl_pkg;

  // =====================================================================
  // unlock tracker states
  typedef enum logic [2:0] {
    FWL_UNL_IDLE  = 3'b001,
    FWL_UNL_KEY1  = 3'b010,
    FWL_UNL_ARMED = 3'b100
  } fwl_unlock_e;

  // =====================================================================
  // operation sequencer states
  typedef enum logic [3:0] {
    FWL_OP_IDLE  = 4'b0001,
    FWL_OP_NOP   = 4'b0010,
    FWL_OP_BUSY  = 4'b0100,
    FWL_OP_CLEAR = 4'b1000
  } fwl_op_e;

  typedef logic [13:0] fwl_word_t;

endpackage

//--- fwl_unlock.sv
// unlock key tracker: 55h then aah then a trigger write, uninterrupted
`include "fwl_regs.svh"
module fwl_unlock (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  input  wire logic       other_wr,
  input  wire logic       trig_wr,
  output logic            unlocked,
  output logic            seq_bad
);

  fwl_pkg::fwl_unlock_e state_reg;
  fwl_pkg::fwl_unlock_e state_next;

  // =====================================================================
  // next state: any other register write breaks the sequence
  always_comb begin
    state_next = state_reg;
    unlocked   = 1'b0;
    seq_bad    = 1'b0;
    if (trig_wr) begin
      unlocked   = (state_reg == fwl_pkg::FWL_UNL_ARMED);
      seq_bad    = (state_reg != fwl_pkg::FWL_UNL_ARMED);
      state_next = fwl_pkg::FWL_UNL_IDLE;
    end else if (key_wr) begin
      if (key_data == `FWL_KEY_FIRST) begin
        state_next = fwl_pkg::FWL_UNL_KEY1;
      end else if (key_data == `FWL_KEY_SECOND && state_reg == fwl_pkg::FWL_UNL_KEY1) begin
        state_next = fwl_pkg::FWL_UNL_ARMED;
      end else begin
        state_next = fwl_pkg::FWL_UNL_IDLE;
      end
    end else if (other_wr) begin
      state_next = fwl_pkg::FWL_UNL_IDLE; // interrupted sequence
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= fwl_pkg::FWL_UNL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

//--- fwl_latch_bank.sv
// bank of row write latches, reset to blank in one cycle
`include "fwl_regs.svh"
module fwl_latch_bank #(
  parameter int COUNT = `FWL_LATCH_COUNT,
  parameter int AW    = `FWL_LATCH_AW
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              load,
  input  wire logic [AW-1:0]     load_idx,
  input  wire fwl_pkg::fwl_word_t load_word,
  input  wire logic              blank_all,
  input  wire logic [AW-1:0]     rd_idx,
  output fwl_pkg::fwl_word_t     rd_word
);

  fwl_pkg::fwl_word_t mem_reg  [COUNT];
  fwl_pkg::fwl_word_t mem_next [COUNT];

  // =====================================================================
  // blanking wins over a load in the same cycle
  always_comb begin
    for (int i = 0; i < COUNT; i++) begin
      mem_next[i] = mem_reg[i];
      if (blank_all) begin
        mem_next[i] = `FWL_BLANK_WORD;
      end else if (load && load_idx == AW'(i)) begin
        mem_next[i] = load_word;
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < COUNT; i++) begin
      if (!rst_b) begin
        mem_reg[i] <= `FWL_BLANK_WORD;
      end else begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end

  assign rd_word = mem_reg[rd_idx];

endmodule

//--- fwl_sequencer.sv
// flash row write latch sequencer: registers, unlock, latch load, row program/erase timing
//
// Our own choices: the placing of the registers and strobed register access.
`include "fwl_regs.svh"
module fwl_sequencer #(
  parameter int PROG_CYCLES = `FWL_PROG_CYCLES
) (
  input  wire logic       MCLK,
  input  wire logic       RST_B,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR_STB,
  input  wire logic       RD_STB,
  output logic      [7:0] RDATA,
  output logic            CPU_NOP,
  output logic            CPU_STALL,
  output logic            FLASH_PROG,
  output logic            FLASH_ERASE,
  output logic      [9:0] FLASH_ROW,
  output logic      [4:0] FLASH_IDX,
  output logic     [13:0] FLASH_WORD
);

  // =====================================================================
  // register state
  logic [7:0]  prog_data_low_reg, prog_data_low_next;
  logic [5:0]  prog_data_high_reg, prog_data_high_next;
  logic [7:0]  prog_addr_low_reg, prog_addr_low_next;
  logic [6:0]  prog_addr_high_reg, prog_addr_high_next;
  logic        config_space_select_reg, config_space_select_next;
  logic        latch_only_mode_reg, latch_only_mode_next;
  logic        erase_mode_reg, erase_mode_next;
  logic        sequence_error_flag_reg, sequence_error_flag_next;
  logic        write_enable_bit_reg, write_enable_bit_next;
  logic        trigger_reg, trigger_next;
  logic [7:0]  rdata_reg, rdata_next;

  fwl_pkg::fwl_op_e op_reg, op_next;
  logic [31:0] cnt_reg, cnt_next;
  logic        is_prog_reg, is_prog_next;
  logic [9:0]  row_reg, row_next;
  logic [4:0]  idx_reg, idx_next;
  logic        nop_reg, nop_next;
  logic        stall_reg, stall_next;
  logic        fprog_reg, fprog_next;
  logic        ferase_reg, ferase_next;
  logic [13:0] fword_reg, fword_next;

  // =====================================================================
  // strobe decode
  logic ctl_wr, key_wr, other_wr, trig_wr, unlocked, seq_bad;
  logic latch_load, blank_all;
  fwl_pkg::fwl_word_t rd_word;

  assign ctl_wr   = WR_STB && ADDR == `FWL_OFS_CONTROL_ONE;
  assign key_wr   = WR_STB && ADDR == `FWL_OFS_UNLOCK_PORT;
  assign trig_wr  = ctl_wr && WDATA[`FWL_BIT_TRIGGER] && !trigger_reg;
  assign other_wr = WR_STB && !key_wr && !trig_wr;

  fwl_unlock u_unlock (
    .clk      (MCLK),
    .rst_b    (RST_B),
    .key_wr   (key_wr),
    .key_data (WDATA),
    .other_wr (other_wr),
    .trig_wr  (trig_wr),
    .unlocked (unlocked),
    .seq_bad  (seq_bad)
  );

  // a good start needs the full unlock, write enable and program space
  logic good_start;
  assign good_start = unlocked && write_enable_bit_reg && !config_space_select_reg;

  // latch load happens for program and latch-only starts, never for erase
  assign latch_load = good_start && !erase_mode_reg;
  // latch-only loads keep the bank; only a program or an erase blanks it
  assign blank_all  = op_reg == fwl_pkg::FWL_OP_CLEAR && (is_prog_reg || erase_mode_reg);

  fwl_latch_bank u_bank (
    .clk       (MCLK),
    .rst_b     (RST_B),
    .load      (latch_load),
    .load_idx  (prog_addr_low_reg[4:0]),
    .load_word ({prog_data_high_reg, prog_data_low_reg}),
    .blank_all (blank_all),
    .rd_idx    (idx_reg),
    .rd_word   (rd_word)
  );

  // =====================================================================
  // register file next values
  always_comb begin
    prog_data_low_next       = prog_data_low_reg;
    prog_data_high_next      = prog_data_high_reg;
    prog_addr_low_next       = prog_addr_low_reg;
    prog_addr_high_next      = prog_addr_high_reg;
    config_space_select_next = config_space_select_reg;
    latch_only_mode_next     = latch_only_mode_reg;
    erase_mode_next          = erase_mode_reg;
    write_enable_bit_next    = write_enable_bit_reg;
    sequence_error_flag_next = sequence_error_flag_reg;
    trigger_next             = trigger_reg;
    if (WR_STB) begin
      if (ADDR == `FWL_OFS_DATA_LOW) begin
        prog_data_low_next = WDATA;
      end else if (ADDR == `FWL_OFS_DATA_HIGH) begin
        prog_data_high_next = WDATA[5:0];
      end else if (ADDR == `FWL_OFS_ADDR_LOW) begin
        prog_addr_low_next = WDATA;
      end else if (ADDR == `FWL_OFS_ADDR_HIGH) begin
        prog_addr_high_next = WDATA[6:0];
      end else if (ADDR == `FWL_OFS_CONTROL_ONE) begin
        config_space_select_next = WDATA[`FWL_BIT_CONFIG_SPACE_SELECT];
        latch_only_mode_next     = WDATA[`FWL_BIT_LATCH_ONLY_MODE];
        erase_mode_next          = WDATA[`FWL_BIT_ERASE];
        write_enable_bit_next    = WDATA[`FWL_BIT_WRITE_ENABLE_BIT];
        sequence_error_flag_next = WDATA[`FWL_BIT_ERR];
      end
    end
    // set only: software cannot clear the trigger
    if (good_start) begin
      trigger_next = 1'b1;
    end
    if (op_reg == fwl_pkg::FWL_OP_CLEAR) begin
      trigger_next = 1'b0;
      if (erase_mode_reg && !is_prog_reg) begin
        erase_mode_next = 1'b0; // erase enable is hardware cleared
      end
    end
    // error set wins over a software clear in the same cycle
    if (seq_bad || (trig_wr && !good_start)) begin
      sequence_error_flag_next = 1'b1;
    end
  end

  // =====================================================================
  // operation sequencer: two no-op cycles, optional stall, blanking
  always_comb begin
    op_next      = op_reg;
    cnt_next     = cnt_reg;
    is_prog_next = is_prog_reg;
    row_next     = row_reg;
    idx_next     = idx_reg;
    fprog_next   = 1'b0;
    ferase_next  = 1'b0;
    fword_next   = fword_reg;
    case (op_reg)
      fwl_pkg::FWL_OP_IDLE: begin
        if (good_start) begin
          op_next      = fwl_pkg::FWL_OP_NOP;
          cnt_next     = 32'(`FWL_NOP_CYCLES - 1);
          is_prog_next = !erase_mode_reg && !latch_only_mode_reg;
          row_next     = {prog_addr_high_reg, prog_addr_low_reg[7:5]};
          idx_next     = 5'h00;
        end
      end
      fwl_pkg::FWL_OP_NOP: begin
        if (cnt_reg == 32'h0) begin
          if (is_prog_reg || erase_mode_reg) begin
            op_next  = fwl_pkg::FWL_OP_BUSY;
            cnt_next = 32'(PROG_CYCLES - 1);
          end else begin
            op_next = fwl_pkg::FWL_OP_CLEAR; // latch load: no stall
          end
        end else begin
          cnt_next = cnt_reg - 32'h1;
        end
      end
      fwl_pkg::FWL_OP_BUSY: begin
        if (cnt_reg == 32'h0) begin
          op_next = fwl_pkg::FWL_OP_CLEAR;
        end else begin
          cnt_next = cnt_reg - 32'h1;
        end
      end
      fwl_pkg::FWL_OP_CLEAR: begin
        op_next = fwl_pkg::FWL_OP_IDLE;
      end
      default: begin
        op_next = fwl_pkg::FWL_OP_IDLE;
      end
    endcase
    // flash strobes follow the next state, so they line up with the stall
    if (op_next == fwl_pkg::FWL_OP_BUSY) begin
      // no erase pulse on a program: the row is written as it stands
      if (is_prog_reg) begin
        fprog_next = 1'b1;
        fword_next = rd_word;
        idx_next   = idx_reg + 5'h01; // wraps inside the row
      end else begin
        ferase_next = 1'b1;
      end
    end
    // no-op and stall flags are registered from the next state
    nop_next   = op_next == fwl_pkg::FWL_OP_NOP;
    stall_next = op_next == fwl_pkg::FWL_OP_BUSY;
  end

  // =====================================================================
  // read data, one cycle after the read strobe
  always_comb begin
    rdata_next = 8'h00;
    if (RD_STB) begin
      if (ADDR == `FWL_OFS_DATA_LOW) begin
        rdata_next = prog_data_low_reg;
      end else if (ADDR == `FWL_OFS_DATA_HIGH) begin
        rdata_next = {2'b00, prog_data_high_reg};
      end else if (ADDR == `FWL_OFS_ADDR_LOW) begin
        rdata_next = prog_addr_low_reg;
      end else if (ADDR == `FWL_OFS_ADDR_HIGH) begin
        rdata_next = {1'b1, prog_addr_high_reg};
      end else if (ADDR == `FWL_OFS_CONTROL_ONE) begin
        rdata_next = {1'b1, config_space_select_reg, latch_only_mode_reg, erase_mode_reg,
                      sequence_error_flag_reg, write_enable_bit_reg, trigger_reg, 1'b0};
      end else if (ADDR == `FWL_OFS_STATUS) begin
        rdata_next = {4'h0, op_reg};
      end
    end
  end

  // =====================================================================
  // registers
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      prog_data_low_reg       <= 8'h00;
      prog_data_high_reg      <= 6'h00;
      prog_addr_low_reg       <= 8'h00;
      prog_addr_high_reg      <= 7'h00;
      config_space_select_reg <= 1'b0;
      latch_only_mode_reg     <= 1'b0;
      erase_mode_reg          <= 1'b0;
      write_enable_bit_reg    <= 1'b0;
      sequence_error_flag_reg <= 1'b0;
      trigger_reg             <= 1'b0;
      rdata_reg               <= 8'h00;
      op_reg                  <= fwl_pkg::FWL_OP_IDLE;
      cnt_reg                 <= 32'h0;
      is_prog_reg             <= 1'b0;
      row_reg                 <= 10'h000;
      idx_reg                 <= 5'h00;
      nop_reg                 <= 1'b0;
      stall_reg               <= 1'b0;
      fprog_reg               <= 1'b0;
      ferase_reg              <= 1'b0;
      fword_reg               <= 14'h0000;
    end else begin
      prog_data_low_reg       <= prog_data_low_next;
      prog_data_high_reg      <= prog_data_high_next;
      prog_addr_low_reg       <= prog_addr_low_next;
      prog_addr_high_reg      <= prog_addr_high_next;
      config_space_select_reg <= config_space_select_next;
      latch_only_mode_reg     <= latch_only_mode_next;
      erase_mode_reg          <= erase_mode_next;
      write_enable_bit_reg    <= write_enable_bit_next;
      sequence_error_flag_reg <= sequence_error_flag_next;
      trigger_reg             <= trigger_next;
      rdata_reg               <= rdata_next;
      op_reg                  <= op_next;
      cnt_reg                 <= cnt_next;
      is_prog_reg             <= is_prog_next;
      row_reg                 <= row_next;
      idx_reg                 <= idx_next;
      nop_reg                 <= nop_next;
      stall_reg               <= stall_next;
      fprog_reg               <= fprog_next;
      ferase_reg              <= ferase_next;
      fword_reg               <= fword_next;
    end
  end

  // idx_reg runs one step ahead of the word, so delay it one cycle to line up
  logic [4:0] fidx_reg;
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      fidx_reg <= 5'h00;
    end else begin
      fidx_reg <= idx_reg;
    end
  end

  assign RDATA       = rdata_reg;
  assign CPU_NOP     = nop_reg;
  assign CPU_STALL   = stall_reg;
  assign FLASH_PROG  = fprog_reg;
  assign FLASH_ERASE = ferase_reg;
  assign FLASH_ROW   = row_reg;
  assign FLASH_IDX   = fidx_reg;
  assign FLASH_WORD  = fword_reg;

endmodule

//--- fwl_sequencer_assertions.sv
// port checker for the flash row write sequencer
module fwl_sequencer_checker #(
  parameter int PROG_CYCLES = 40
) (
  input wire logic        MCLK,
  input wire logic        RST_B,
  input wire logic [3:0]  ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR_STB,
  input wire logic        RD_STB,
  input wire logic [7:0]  RDATA,
  input wire logic        CPU_NOP,
  input wire logic        CPU_STALL,
  input wire logic        FLASH_PROG,
  input wire logic        FLASH_ERASE,
  input wire logic [9:0]  FLASH_ROW,
  input wire logic [4:0]  FLASH_IDX,
  input wire logic [13:0] FLASH_WORD
);
  int stall_cnt;

  // =====================================================================
  // run length of the stall, so a stuck or short timer shows up
  always_ff @(posedge MCLK) begin
    if (!RST_B) stall_cnt <= 0;
    else if (CPU_STALL) stall_cnt <= stall_cnt + 1;
    else stall_cnt <= 0;
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  // =====================================================================
  // properties
  nop_two_a: assert property ($rose(CPU_NOP) |=> CPU_NOP ##1 !CPU_NOP)
    else $error("forced no-op not two cycles");
  stall_after_a: assert property ($rose(CPU_STALL) |-> $past(CPU_NOP) && !CPU_NOP)
    else $error("stall not right after no-ops");
  stall_len_a: assert property ($fell(CPU_STALL) |-> stall_cnt == PROG_CYCLES)
    else $error("stall length wrong");
  stall_bound_a: assert property (CPU_STALL |-> stall_cnt < PROG_CYCLES)
    else $error("stall too long");
  prog_in_stall_a: assert property (FLASH_PROG |-> CPU_STALL)
    else $error("program outside stall");
  no_auto_erase_a: assert property (FLASH_PROG |-> !FLASH_ERASE)
    else $error("erase during program");
  row_held_a: assert property (CPU_STALL && $past(CPU_STALL) |-> $stable(FLASH_ROW))
    else $error("row moved during operation");
  idx_first_a: assert property ($rose(FLASH_PROG) |-> FLASH_IDX == 5'h00)
    else $error("first latch index not zero");
  idx_step_a: assert property (FLASH_PROG && $past(FLASH_PROG) |-> FLASH_IDX == $past(FLASH_IDX) + 5'h01)
    else $error("latch index did not step");
  rdata_idle_a: assert property (!$past(RD_STB) |-> RDATA == 8'h00)
    else $error("read data outside read cycle");
endmodule

bind fwl_sequencer fwl_sequencer_checker #(.PROG_CYCLES(PROG_CYCLES)) fwl_sequencer_checker_i (
  .MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB),
  .RDATA(RDATA), .CPU_NOP(CPU_NOP), .CPU_STALL(CPU_STALL), .FLASH_PROG(FLASH_PROG),
  .FLASH_ERASE(FLASH_ERASE), .FLASH_ROW(FLASH_ROW), .FLASH_IDX(FLASH_IDX), .FLASH_WORD(FLASH_WORD));

//--- tb.sv
// self-checking bench for the flash row write sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG_CYCLES = 40;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [7:0]  rdata;
  logic        cpu_nop, cpu_stall, flash_prog, flash_erase;
  logic [9:0]  flash_row, row, row_seen;
  logic [4:0]  flash_idx;
  logic [13:0] flash_word;
  logic [13:0] lat [32];
  logic [13:0] seen [32];
  logic [31:0] seed = 32'ha161;
  logic [7:0]  bad [4] = '{8'h04, 8'h20, 8'h64, 8'h24};
  int          errors = 0, n_tests = 0, cyc = 0;
  int          nop_n, stall_n, prog_n, erase_n;

  always #10 mclk = ~mclk;

  fwl_sequencer #(.PROG_CYCLES(PROG_CYCLES)) fwl_sequencer_i (
    .MCLK(mclk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .RDATA(rdata), .CPU_NOP(cpu_nop), .CPU_STALL(cpu_stall), .FLASH_PROG(flash_prog),
    .FLASH_ERASE(flash_erase), .FLASH_ROW(flash_row), .FLASH_IDX(flash_idx), .FLASH_WORD(flash_word));

  // =====================================================================
  // monitor on the falling edge, where outputs are settled
  always @(negedge mclk) begin
    if (flash_prog === 1'b1) begin
      seen[flash_idx] = flash_word;
      row_seen = flash_row;
      prog_n++;
    end
    if (cpu_nop === 1'b1) nop_n++;
    if (cpu_stall === 1'b1) stall_n++;
    if (flash_erase === 1'b1) erase_n++;
  end

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      final_report();
    end
  end

  // =====================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one bus cycle; strobes are retargeted each edge so back-to-back needs no gap
  task automatic op(input logic w, input logic [3:0] a, input logic [7:0] d);
    wr_stb <= w;
    rd_stb <= !w;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    op(1'b0, a, 8'h00);
    rd_stb <= 1'b0;
    #1;
    chk({24'h0, rdata}, {24'h0, exp}, what);
    @(posedge mclk);
  endtask

  task automatic unlock(input logic [7:0] ctl);
    nop_n = 0;
    stall_n = 0;
    prog_n = 0;
    erase_n = 0;
    // mode bits settle before the keys, the trigger write only adds the trigger
    op(1'b1, 4'h4, ctl);
    op(1'b1, 4'h5, 8'h55);
    op(1'b1, 4'h5, 8'haa);
    op(1'b1, 4'h4, ctl | 8'h02);
    wr_stb <= 1'b0;
    @(posedge mclk);
  endtask

  // address, data then unlock; top data bits are junk that must be dropped
  task automatic load(input logic [4:0] idx, input logic [7:0] ctl);
    logic [31:0] t;
    t = rnd();
    op(1'b1, 4'h2, {row[2:0], idx});
    op(1'b1, 4'h3, {1'b0, row[9:3]});
    op(1'b1, 4'h0, t[7:0]);
    op(1'b1, 4'h1, t[15:8]);
    unlock(ctl);
    lat[idx] = t[13:0];
  endtask

  // n latch-only loads, optional row erase, then the committing load
  task automatic round(input int n_lo, input logic erase);
    logic [31:0] t;
    t = rnd();
    row = t[14:5];
    for (int i = 0; i < n_lo; i++) begin
      t = rnd();
      load((i == 0) ? 5'h00 : (i == 1) ? 5'h1f : t[4:0], 8'h24);
      repeat (4) @(posedge mclk);
      chk(nop_n, 2, "latch-only no-op");
      chk(stall_n + prog_n, 0, "latch-only stall");
    end
    if (erase) begin
      unlock(8'h14);
      repeat (PROG_CYCLES + 6) @(posedge mclk);
      chk(erase_n, PROG_CYCLES, "erase cycles");
      chk(prog_n, 0, "erase programs nothing");
      for (int i = 0; i < 32; i++) lat[i] = 14'h3fff;
    end
    t = rnd();
    load(t[4:0], 8'h04);
    op(1'b1, 4'h4, 8'h04);
    rd(4'h4, 8'h86, "trigger held");
    repeat (PROG_CYCLES + 4) @(posedge mclk);
    chk(prog_n, PROG_CYCLES, "program cycles");
    chk(stall_n, PROG_CYCLES, "stall cycles");
    chk(nop_n, 2, "program no-op");
    chk(erase_n, 0, "no erase on program");
    chk(row_seen, row, "row");
    for (int i = 0; i < 32; i++) begin
      chk(seen[i], lat[i], "latch word");
      lat[i] = 14'h3fff;
    end
    rd(4'h4, 8'h84, "trigger cleared");
  endtask

  // =====================================================================
  // main sequence
  initial begin
    for (int i = 0; i < 32; i++) lat[i] = 14'h3fff;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    rd(4'h3, 8'h80, "addr_high reset");
    rd(4'h4, 8'h80, "control reset");
    rd(4'h6, 8'h01, "status idle");
    rd(4'h5, 8'h00, "unlock port");
    rd(4'h7, 8'h00, "unmapped");
    op(1'b1, 4'h1, 8'hff);
    rd(4'h1, 8'h3f, "data_high mask");
    // bare trigger, no enable, config space, interrupted unlock
    for (int c = 0; c < 4; c++) begin
      nop_n = 0;
      op(1'b1, 4'h4, bad[c]);
      if (c != 0) op(1'b1, 4'h5, 8'h55);
      if (c == 3) op(1'b1, 4'h0, 8'h12);
      if (c != 0) op(1'b1, 4'h5, 8'haa);
      op(1'b1, 4'h4, bad[c] | 8'h02);
      wr_stb <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(nop_n, 0, "bad start no-op");
      rd(4'h4, 8'h88 | bad[c], "error flag");
      op(1'b1, 4'h4, 8'h00);
    end
    round(5, 1'b0);
    round(0, 1'b0);
    round(1, 1'b1);
    final_report();
  end
endmodule
